// ### src/keypad_defs.svh
// Register offsets, field positions, reset values and interrupt layout for the keypad unit.
`ifndef KEYPAD_DEFS_SVH
`define KEYPAD_DEFS_SVH
`define KEY_NUM_LINES      7
`define KEY_SC_OFFSET      8'h1A
`define KEY_EN_OFFSET      8'h1B
`define KEY_IRQ_ST_OFFSET  8'h1C
`define KEY_IRQ_MSK_OFFSET 8'h1D
`define KEY_SC_PEND_BIT    3
`define KEY_SC_ACK_BIT     2
`define KEY_SC_MASK_BIT    1
`define KEY_SC_MODE_BIT    0
`define KEY_SC_RESET       8'h00
`define KEY_EN_RESET       7'h00
`define KEY_IRQ_RESET      1'h0
`endif

// ### src/keypad_pkg.sv
// Types shared by the keypad unit.
package keypad_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;
endpackage

// ### src/key_line_detect.sv
// Falling edge and held low detector for the enabled key lines.
`include "keypad_defs.svh"
module key_line_detect (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // Key lines and enables
  input  wire logic [`KEY_NUM_LINES-1:0] key_lines_in,
  input  wire logic [`KEY_NUM_LINES-1:0] key_enable_in,
  // Detection results
  output logic                           key_edge_out,
  output logic                           key_level_out
);
  typedef struct packed {
    logic [`KEY_NUM_LINES-1:0] prev;
    logic                      edge_seen;
    logic                      level_seen;
  } det_s;
  det_s st_r;
  det_s st_nxt;
  always_comb begin
    st_nxt = st_r;
    // Idle high lines are assumed; a disabled line counts as high.
    st_nxt.prev       = key_lines_in | ~key_enable_in;
    st_nxt.edge_seen  = |(st_r.prev & ~(key_lines_in | ~key_enable_in));
    st_nxt.level_seen = |(key_enable_in & ~key_lines_in);
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '{prev: {`KEY_NUM_LINES{1'b1}}, edge_seen: 1'b0, level_seen: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign key_edge_out  = st_r.edge_seen;
  assign key_level_out = st_r.level_seen;
endmodule

// ### src/keypad_wakeup_unit.sv
// Keypad wakeup interrupt unit with a classic Wishbone register slave.
//
// Our own choice: the Wishbone interface to the registers.
`include "keypad_defs.svh"
module keypad_wakeup_unit (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rst_n_in,
  // Wishbone slave
  input  wire logic                      wb_cyc_in,
  input  wire logic                      wb_stb_in,
  input  wire logic                      wb_we_in,
  input  wire logic [7:0]                wb_adr_in,
  input  wire logic [7:0]                wb_dat_in,
  input  wire logic                      wb_sel_in,
  output logic [7:0]                     wb_dat_out,
  output logic                           wb_ack_out,
  // Key pins and system control
  input  wire logic [`KEY_NUM_LINES-1:0] key_lines_in,
  input  wire logic                      break_state_in,
  input  wire logic                      break_clear_allow_in,
  // Pull-up enable for the key pins
  output logic [`KEY_NUM_LINES-1:0]      key_pullup_en_out,
  // Interrupts
  output logic                           key_cpu_irq_out,
  output logic                           wakeup_out,
  output logic                           irq_out
);
  typedef struct packed {
    keypad_pkg::bus_state_e    bus;
    logic [7:0]                rdata;
    logic                      pending;
    logic                      mask;
    logic                      mode;
    logic [`KEY_NUM_LINES-1:0] enable;
    logic [1:0]                irq_status;
    logic [1:0]                irq_mask;
  } unit_s;

  unit_s st_r;
  unit_s st_nxt;
  logic  edge_hit;
  logic  level_hit;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // ==========================================================
  // Line detection
  key_line_detect u_detect (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .key_lines_in  (key_lines_in),
    .key_enable_in (st_r.enable),
    .key_edge_out  (edge_hit),
    .key_level_out (level_hit)
  );

  // ==========================================================
  // Next state
  always_comb begin
    logic wr;
    logic rd_sc;
    logic ack_wr;
    logic ack_ok;
    logic set_req;
    wr      = 1'b0;
    rd_sc   = 1'b0;
    ack_wr  = 1'b0;
    ack_ok  = 1'b0;
    set_req = 1'b0;
    st_nxt  = st_r;
    unique case (st_r.bus)
      keypad_pkg::BUS_IDLE: begin
        if (wb_cyc_in && wb_stb_in) begin
          st_nxt.bus = keypad_pkg::BUS_ACK;
          wr         = wb_we_in && wb_sel_in;
          rd_sc      = 1'b1;
        end
      end
      keypad_pkg::BUS_ACK: begin
        st_nxt.bus = keypad_pkg::BUS_IDLE;
      end
    endcase
    // Read data; unmapped addresses read zero.
    if (rd_sc) begin
      st_nxt.rdata = 8'h00;
      if (hit(wb_adr_in, `KEY_SC_OFFSET)) begin
        st_nxt.rdata = {4'h0, st_r.pending, 1'b0, st_r.mask, st_r.mode};
      end else if (hit(wb_adr_in, `KEY_EN_OFFSET)) begin
        st_nxt.rdata = {1'b0, st_r.enable};
      end else if (hit(wb_adr_in, `KEY_IRQ_ST_OFFSET)) begin
        st_nxt.rdata = {6'h00, st_r.irq_status};
      end else if (hit(wb_adr_in, `KEY_IRQ_MSK_OFFSET)) begin
        st_nxt.rdata = {6'h00, st_r.irq_mask};
      end
    end
    if (wr && hit(wb_adr_in, `KEY_SC_OFFSET)) begin
      st_nxt.mask = wb_dat_in[`KEY_SC_MASK_BIT];
      st_nxt.mode = wb_dat_in[`KEY_SC_MODE_BIT];
      ack_wr      = wb_dat_in[`KEY_SC_ACK_BIT];
    end
    if (wr && hit(wb_adr_in, `KEY_EN_OFFSET)) begin
      st_nxt.enable = wb_dat_in[`KEY_NUM_LINES-1:0];
    end
    if (wr && hit(wb_adr_in, `KEY_IRQ_MSK_OFFSET)) begin
      st_nxt.irq_mask = wb_dat_in[1:0];
    end
    ack_ok = ack_wr && (!break_state_in || break_clear_allow_in);
    // Edge or edge and level request
    set_req = edge_hit || (st_r.mode && level_hit);
    if (ack_ok) begin
      st_nxt.pending = 1'b0;
    end
    if (set_req) begin
      st_nxt.pending = 1'b1;
    end
    // Sticky status: bit 0 key request, bit 1 ignored acknowledge in break.
    if (wr && hit(wb_adr_in, `KEY_IRQ_ST_OFFSET)) begin
      st_nxt.irq_status = st_r.irq_status & ~wb_dat_in[1:0];
    end
    if (set_req) begin
      st_nxt.irq_status[0] = 1'b1;
    end
    if (ack_wr && !ack_ok) begin
      st_nxt.irq_status[1] = 1'b1;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '{bus: keypad_pkg::BUS_IDLE, rdata: 8'h00, pending: 1'b0,
                mask: 1'b0, mode: 1'b0, enable: `KEY_EN_RESET,
                irq_status: 2'h0, irq_mask: 2'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_out = (st_r.bus == keypad_pkg::BUS_ACK);
  assign wb_dat_out = st_r.rdata;
  assign key_pullup_en_out = st_r.enable;
  assign key_cpu_irq_out = st_r.pending && !st_r.mask;
  assign wakeup_out = st_r.pending && !st_r.mask;
  assign irq_out    = |(st_r.irq_status & st_r.irq_mask);
endmodule

// ### dv/keypad_wakeup_unit_props.sv
// Checker of the keypad unit bus and request behaviour.
`include "keypad_defs.svh"
module keypad_wakeup_unit_props (
  // Bus side
  input wire logic       clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_sel_in,
  input wire logic [7:0] wb_adr_in, wb_dat_in, wb_dat_out,
  input wire logic       wb_ack_out, break_state_in, break_clear_allow_in,
  // Key side
  input wire logic [6:0] key_lines_in, key_pullup_en_out,
  input wire logic       key_cpu_irq_out, wakeup_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic wr;
  logic idle;
  assign wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in & !wb_ack_out;
  assign idle = &(key_lines_in | ~key_pullup_en_out);
  chk_ack_next:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  chk_ack_once:
    assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  chk_sc_read:
    assert property (wb_ack_out && !wb_we_in && wb_adr_in == `KEY_SC_OFFSET
    |-> wb_dat_out[7:4] == 4'h0 && !wb_dat_out[2])
    else $error("status read bad");
  chk_en_read:
    assert property (wb_ack_out && !wb_we_in && wb_adr_in == `KEY_EN_OFFSET
    |-> wb_dat_out == {1'b0, key_pullup_en_out})
    else $error("enable read bad");
  chk_en_write:
    assert property (wr && wb_adr_in == `KEY_EN_OFFSET
    |=> key_pullup_en_out == $past(wb_dat_in[6:0]))
    else $error("pullup bad");
  chk_mask_block:
    assert property (wr && wb_adr_in == `KEY_SC_OFFSET && wb_dat_in[1]
    |=> !key_cpu_irq_out)
    else $error("mask leak");
  chk_ack_clear:
    assert property (wr && wb_adr_in == `KEY_SC_OFFSET && wb_dat_in[2:0] == 3'h4
    && (!break_state_in || break_clear_allow_in) && idle && $past(idle) && $past(idle, 2)
    |=> !key_cpu_irq_out)
    else $error("ack kept");
  chk_break_keep:
    assert property (wr && wb_adr_in == `KEY_SC_OFFSET && wb_dat_in[2:0] == 3'h4
    && break_state_in && !break_clear_allow_in && key_cpu_irq_out |=> key_cpu_irq_out)
    else $error("break ack took");
  chk_wake_irq:
    assert property (wakeup_out == key_cpu_irq_out)
    else $error("wake differs");
endmodule
bind keypad_wakeup_unit keypad_wakeup_unit_props i_keypad_wakeup_unit_props (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_sel_in(wb_sel_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .break_state_in(break_state_in),
  .break_clear_allow_in(break_clear_allow_in), .key_lines_in(key_lines_in),
  .key_pullup_en_out(key_pullup_en_out), .key_cpu_irq_out(key_cpu_irq_out),
  .wakeup_out(wakeup_out));

// ### dv/key_switches.sv
// Model of the key switches on the port A pins.
module key_switches (
  // Clock
  input  wire logic       clk_in,
  // Pull-ups and presses
  input  wire logic [6:0] pullup_en_in,
  input  wire logic [6:0] press_in,
  // Key pins
  output logic      [6:0] key_lines_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] float_r = 7'h00;
  // A line with no pull-up floats and toggles every cycle.
  always @(posedge clk_in) float_r <= ~float_r;
  // Pull-up holds an unpressed line high; without it the line follows the float toggle.
  assign key_lines_out = (pullup_en_in | float_r) & ~press_in;
endmodule

// ### dv/tb_keypad_wakeup_unit.sv
// Testbench of the keypad wakeup unit.
`include "keypad_defs.svh"
module tb_keypad_wakeup_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SC = `KEY_SC_OFFSET, EN = `KEY_EN_OFFSET;
  localparam logic [7:0] ST = `KEY_IRQ_ST_OFFSET, MK = `KEY_IRQ_MSK_OFFSET;
  logic clk_in = 0, rst_n_in = 0, cyc = 0, stb = 0, we = 0, sel = 0, brk = 0, allow = 0;
  logic [7:0] adr = 8'h00, dat = 8'h00, rdat, q;
  logic ack, irq, cpu_irq, wake;
  logic [6:0] lines, pull, press = 7'h00;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  always #50 clk_in = ~clk_in;
  key_switches i_key_switches (.clk_in(clk_in), .pullup_en_in(pull), .press_in(press),
    .key_lines_out(lines));
  keypad_wakeup_unit i_keypad_wakeup_unit (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat),
    .wb_sel_in(sel), .wb_dat_out(rdat), .wb_ack_out(ack), .key_lines_in(lines),
    .break_state_in(brk), .break_clear_allow_in(allow), .key_pullup_en_out(pull),
    .key_cpu_irq_out(cpu_irq), .wakeup_out(wake), .irq_out(irq));
  task final_report;
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {cyc, stb, we, sel, adr, dat} <= {1'b1, 1'b1, w, 1'b1, a, d};
    do @(posedge clk_in); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task keys(input logic [6:0] k, input logic b, input logic al);
    @(posedge clk_in);
    {press, brk, allow} <= {k, b, al};
    repeat (4) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report;
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(SC, 8'h00);
    rd(EN, 8'h00);
    rd(8'h30, 8'h00);
    bus(1'b1, SC, 8'h02);
    bus(1'b1, EN, 8'h7F);
    rd(EN, 8'h7F);
    bus(1'b1, SC, 8'h06);
    rd(SC, 8'h02);
    bus(1'b1, SC, 8'h00);
    keys(7'h08, 1'b0, 1'b0);
    rd(SC, 8'h08);
    chk({6'h00, cpu_irq, wake}, 8'h03);
    keys(7'h00, 1'b0, 1'b0);
    bus(1'b1, SC, 8'h04);
    rd(SC, 8'h00);
    bus(1'b1, EN, 8'h00);
    bus(1'b1, EN, 8'h7F);
    rd(SC, 8'h00);
    bus(1'b1, SC, 8'h02);
    keys(7'h01, 1'b0, 1'b0);
    rd(SC, 8'h0A);
    chk({7'h00, cpu_irq}, 8'h00);
    keys(7'h00, 1'b0, 1'b0);
    bus(1'b1, SC, 8'h05);
    keys(7'h40, 1'b0, 1'b0);
    rd(SC, 8'h09);
    bus(1'b1, SC, 8'h05);
    rd(SC, 8'h09);
    keys(7'h00, 1'b0, 1'b0);
    bus(1'b1, SC, 8'h05);
    rd(SC, 8'h01);
    bus(1'b1, SC, 8'h00);
    keys(7'h02, 1'b0, 1'b0);
    keys(7'h00, 1'b1, 1'b0);
    bus(1'b1, SC, 8'h04);
    rd(SC, 8'h08);
    keys(7'h00, 1'b1, 1'b1);
    bus(1'b1, SC, 8'h04);
    keys(7'h00, 1'b0, 1'b1);
    rd(SC, 8'h00);
    rd(ST, 8'h03);
    bus(1'b1, MK, 8'h02);
    chk({7'h00, irq}, 8'h01);
    bus(1'b1, MK, 8'h00);
    chk({7'h00, irq}, 8'h00);
    bus(1'b1, MK, 8'h02);
    bus(1'b1, ST, 8'h03);
    rd(ST, 8'h00);
    chk({7'h00, irq}, 8'h00);
    final_report;
  end
endmodule
